// >>> hdl/group_flag_reg.sv
`timescale 1ns/100ps
module group_flag_reg #(
	parameter logic [7:0] MASK = 8'h33
) (
	// clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	// software write
	input  wire logic       i_wr,
	input  wire logic [7:0] i_wdata,
	// sub-source events, one per flag bit 7..4
	input  wire logic [3:0] i_set,
	// state
	output logic [7:0]      o_value,
	output logic            o_pending
);
	logic [7:0] value;
	wire  [7:0] set_bits = {i_set, 4'h0} & MASK;
	wire  [7:0] next_value = ((i_wr ? i_wdata : value) | set_bits) & MASK;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			value <= irq_bank_pkg::RESET_VAL;
		end else begin
			value <= next_value;
		end
	end

	assign o_value   = value;
	assign o_pending = |(value[7:4] & value[3:0]);
endmodule

// >>> hdl/irq_bank_pkg.sv
package irq_bank_pkg;
	// register indices on the plain port
	localparam logic [2:0] ADDR_EDGE   = 3'h0;
	localparam logic [2:0] ADDR_CTRL_A = 3'h1;
	localparam logic [2:0] ADDR_CTRL_B = 3'h2;
	localparam logic [2:0] ADDR_CTRL_C = 3'h3;
	localparam logic [2:0] ADDR_GRP0   = 3'h4;
	localparam logic [2:0] ADDR_GRP1   = 3'h5;
	localparam logic [2:0] ADDR_GRP2   = 3'h6;
	localparam int         ADDR_W      = 3;
	localparam int         DATA_W      = 8;
	localparam logic [7:0] RESET_VAL   = 8'h00;
	// implemented-bit masks
	localparam logic [7:0] MASK_EDGE    = 8'h0f;
	localparam logic [7:0] MASK_A_BIG   = 8'h7f;
	localparam logic [7:0] MASK_A_SMALL = 8'h5b;
	localparam logic [7:0] MASK_B       = 8'hff;
	localparam logic [7:0] MASK_C_BIG   = 8'hff;
	localparam logic [7:0] MASK_C_SMALL = 8'h77;
	localparam logic [7:0] MASK_G0      = 8'h33;
	localparam logic [7:0] MASK_G1_BIG  = 8'hff;
	localparam logic [7:0] MASK_G1_SMALL = 8'h33;
	localparam logic [7:0] MASK_G2      = 8'h33;
	// field positions
	localparam int A_GIE  = 0;
	localparam int A_P0E  = 1;
	localparam int A_CPE  = 2;
	localparam int A_G0E  = 3;
	localparam int A_P0F  = 4;
	localparam int A_CPF  = 5;
	localparam int A_G0F  = 6;
	localparam int B_G1E  = 0;
	localparam int B_G2E  = 1;
	localparam int B_ADE  = 2;
	localparam int B_T0E  = 3;
	localparam int B_G1F  = 4;
	localparam int B_G2F  = 5;
	localparam int B_ADF  = 6;
	localparam int B_T0F  = 7;
	localparam int C_T1E  = 0;
	localparam int C_P1E  = 1;
	localparam int C_SIE  = 2;
	localparam int C_URE  = 3;
	localparam int C_T1F  = 4;
	localparam int C_P1F  = 5;
	localparam int C_SIF  = 6;
	localparam int C_URF  = 7;
	localparam int FLAG_OFS = 4;
	// edge-select field
	localparam int EDGE_P0_LSB = 0;
	localparam int EDGE_P1_LSB = 2;
	localparam logic [1:0] EDGE_OFF  = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// vector ids to the sequencer
	localparam int NUM_SRC = 9;
	typedef enum logic [3:0] {
		VEC_NONE = 4'h0,
		VEC_PIN0 = 4'h1,
		VEC_CMP  = 4'h2,
		VEC_GRP0 = 4'h3,
		VEC_TICK0 = 4'h4,
		VEC_CONV = 4'h5,
		VEC_GRP1 = 4'h6,
		VEC_GRP2 = 4'h7,
		VEC_PIN1 = 4'h8,
		VEC_SER  = 4'h9,
		VEC_ASER = 4'ha,
		VEC_TICK1 = 4'hb
	} vec_type;
endpackage

// >>> hdl/irq_flag_enable_bank.sv
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
module irq_flag_enable_bank #(
	parameter bit LARGE = 1'b1
) (
	// clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	// register port
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic [7:0]      o_rdata,
	// external pins
	input  wire logic       i_ext_pin0,
	input  wire logic       i_ext_pin1,
	// internal events, one-cycle pulses
	input  wire logic       i_cmp_evt,
	input  wire logic       i_tick0_evt,
	input  wire logic       i_tick1_evt,
	input  wire logic       i_conv_evt,
	input  wire logic       i_ser_evt,
	input  wire logic       i_aser_evt,
	input  wire logic       i_t0a_evt,
	input  wire logic       i_t0p_evt,
	input  wire logic       i_t1a_evt,
	input  wire logic       i_t1p_evt,
	input  wire logic       i_t2a_evt,
	input  wire logic       i_t2p_evt,
	input  wire logic       i_eeprom_evt,
	input  wire logic       i_low_supply_evt,
	// sequencer side
	input  wire logic       i_ack,
	output logic            o_irq_req,
	output logic [3:0]      o_irq_vec,
	output logic            o_global_irq_enable
);
	localparam logic [7:0] MASK_A  = LARGE ? irq_bank_pkg::MASK_A_BIG : irq_bank_pkg::MASK_A_SMALL;
	localparam logic [7:0] MASK_C  = LARGE ? irq_bank_pkg::MASK_C_BIG : irq_bank_pkg::MASK_C_SMALL;
	localparam logic [7:0] MASK_G1 = LARGE ? irq_bank_pkg::MASK_G1_BIG :
		irq_bank_pkg::MASK_G1_SMALL;

	logic [7:0] pin_edge_select;
	logic [7:0] primary_irq_ctrl_a;
	logic [7:0] primary_irq_ctrl_b;
	logic [7:0] primary_irq_ctrl_c;
	logic [7:0] shared_group_zero;
	logic [7:0] shared_group_one;
	logic [7:0] shared_group_two;
	logic       grp0_pend;
	logic       grp1_pend;
	logic       grp2_pend;
	logic       pin0_evt;
	logic       pin1_evt;
	logic [7:0] rdata;
	logic       grp0_pend_d;
	logic       grp1_pend_d;
	logic       grp2_pend_d;

	// address decode
	wire wr_edge = i_wr && (i_addr == irq_bank_pkg::ADDR_EDGE);
	wire wr_a    = i_wr && (i_addr == irq_bank_pkg::ADDR_CTRL_A);
	wire wr_b    = i_wr && (i_addr == irq_bank_pkg::ADDR_CTRL_B);
	wire wr_c    = i_wr && (i_addr == irq_bank_pkg::ADDR_CTRL_C);
	wire wr_g0   = i_wr && (i_addr == irq_bank_pkg::ADDR_GRP0);
	wire wr_g1   = i_wr && (i_addr == irq_bank_pkg::ADDR_GRP1);
	wire wr_g2   = i_wr && (i_addr == irq_bank_pkg::ADDR_GRP2);

	// edge select fields
	wire [1:0] pin0_edge_sel = pin_edge_select[irq_bank_pkg::EDGE_P0_LSB +: 2];
	wire [1:0] pin1_edge_sel = pin_edge_select[irq_bank_pkg::EDGE_P1_LSB +: 2];

	// external pin triggers
	pin_edge_detect u_pin0 (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_pin     (i_ext_pin0),
		.i_mode    (pin0_edge_sel),
		.o_event   (pin0_evt)
	);
	pin_edge_detect u_pin1 (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_pin     (i_ext_pin1),
		.i_mode    (pin1_edge_sel),
		.o_event   (pin1_evt)
	);

	// shared groups
	group_flag_reg #(.MASK(irq_bank_pkg::MASK_G0)) u_grp0 (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_wr      (wr_g0),
		.i_wdata   (i_wdata),
		.i_set     ({2'h0, i_t0a_evt, i_t0p_evt}),
		.o_value   (shared_group_zero),
		.o_pending (grp0_pend)
	);
	group_flag_reg #(.MASK(MASK_G1)) u_grp1 (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_wr      (wr_g1),
		.i_wdata   (i_wdata),
		.i_set     ({i_t2a_evt, i_t2p_evt, i_t1a_evt, i_t1p_evt}),
		.o_value   (shared_group_one),
		.o_pending (grp1_pend)
	);
	group_flag_reg #(.MASK(irq_bank_pkg::MASK_G2)) u_grp2 (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_wr      (wr_g2),
		.i_wdata   (i_wdata),
		.i_set     ({2'h0, i_eeprom_evt, i_low_supply_evt}),
		.o_value   (shared_group_two),
		.o_pending (grp2_pend)
	);

	// group flag sets when the group goes from no enabled sub-request to one
	wire g0_rise = grp0_pend & ~grp0_pend_d;
	wire g1_rise = grp1_pend & ~grp1_pend_d;
	wire g2_rise = grp2_pend & ~grp2_pend_d;

	// set terms, flags land in the upper nibble
	wire [7:0] set_a = {1'b0, g0_rise, i_cmp_evt, pin0_evt, 4'h0} & MASK_A;
	wire [7:0] set_b = {i_tick0_evt, i_conv_evt, g2_rise, g1_rise, 4'h0};
	wire [7:0] set_c = {i_aser_evt, i_ser_evt, pin1_evt, i_tick1_evt, 4'h0} & MASK_C;

	// per-source active requests, priority control a then b then c, in the order of the vector chain below
	// control a pairs flag n with enable n-3, bit 0 is the global enable
	wire [3:0] act_a = {1'b0, primary_irq_ctrl_a[6:4] & primary_irq_ctrl_a[3:1]};
	wire [3:0] act_b = primary_irq_ctrl_b[7:4] & primary_irq_ctrl_b[3:0];
	wire [3:0] act_c = primary_irq_ctrl_c[7:4] & primary_irq_ctrl_c[3:0];
	wire       gie   = primary_irq_ctrl_a[irq_bank_pkg::A_GIE];
	wire       any   = gie && (|act_a || |act_b || |act_c);

	logic [3:0] vec;
	always_comb begin
		if (!any)
			vec = irq_bank_pkg::VEC_NONE;
		else if (act_a[irq_bank_pkg::A_P0F - irq_bank_pkg::FLAG_OFS])
			vec = irq_bank_pkg::VEC_PIN0;
		else if (act_a[irq_bank_pkg::A_CPF - irq_bank_pkg::FLAG_OFS])
			vec = irq_bank_pkg::VEC_CMP;
		else if (act_a[irq_bank_pkg::A_G0F - irq_bank_pkg::FLAG_OFS])
			vec = irq_bank_pkg::VEC_GRP0;
		else if (act_b[irq_bank_pkg::B_T0F - irq_bank_pkg::FLAG_OFS])
			vec = irq_bank_pkg::VEC_TICK0;
		else if (act_b[irq_bank_pkg::B_ADF - irq_bank_pkg::FLAG_OFS])
			vec = irq_bank_pkg::VEC_CONV;
		else if (act_b[irq_bank_pkg::B_G1F - irq_bank_pkg::FLAG_OFS])
			vec = irq_bank_pkg::VEC_GRP1;
		else if (act_b[irq_bank_pkg::B_G2F - irq_bank_pkg::FLAG_OFS])
			vec = irq_bank_pkg::VEC_GRP2;
		else if (act_c[irq_bank_pkg::C_P1F - irq_bank_pkg::FLAG_OFS])
			vec = irq_bank_pkg::VEC_PIN1;
		else if (act_c[irq_bank_pkg::C_SIF - irq_bank_pkg::FLAG_OFS])
			vec = irq_bank_pkg::VEC_SER;
		else if (act_c[irq_bank_pkg::C_URF - irq_bank_pkg::FLAG_OFS])
			vec = irq_bank_pkg::VEC_ASER;
		else
			vec = irq_bank_pkg::VEC_TICK1;
	end

	// acknowledge clears the served flag and the global enable
	wire        take  = i_ack && any;
	wire [7:0]  clr_a = take ? ({1'b0, vec == irq_bank_pkg::VEC_GRP0, vec == irq_bank_pkg::VEC_CMP,
		vec == irq_bank_pkg::VEC_PIN0, 3'h0, 1'b1}) : 8'h00;
	wire [7:0]  clr_b = take ? ({vec == irq_bank_pkg::VEC_TICK0, vec == irq_bank_pkg::VEC_CONV,
		vec == irq_bank_pkg::VEC_GRP2, vec == irq_bank_pkg::VEC_GRP1, 4'h0}) : 8'h00;
	wire [7:0]  clr_c = take ? ({vec == irq_bank_pkg::VEC_ASER, vec == irq_bank_pkg::VEC_SER,
		vec == irq_bank_pkg::VEC_PIN1, vec == irq_bank_pkg::VEC_TICK1, 4'h0}) : 8'h00;

	// next values: write, then hardware clear, then set wins
	wire [7:0] next_a = (((wr_a ? i_wdata : primary_irq_ctrl_a) & ~clr_a) | set_a)
		& MASK_A;
	wire [7:0] next_b = (((wr_b ? i_wdata : primary_irq_ctrl_b) & ~clr_b) | set_b)
		& irq_bank_pkg::MASK_B;
	wire [7:0] next_c = (((wr_c ? i_wdata : primary_irq_ctrl_c) & ~clr_c) | set_c) & MASK_C;
	wire [7:0] next_edge = (wr_edge ? i_wdata : pin_edge_select) & irq_bank_pkg::MASK_EDGE;

	// read mux
	always_comb begin
		case (i_addr)
			irq_bank_pkg::ADDR_EDGE:   rdata = pin_edge_select;
			irq_bank_pkg::ADDR_CTRL_A: rdata = primary_irq_ctrl_a;
			irq_bank_pkg::ADDR_CTRL_B: rdata = primary_irq_ctrl_b;
			irq_bank_pkg::ADDR_CTRL_C: rdata = primary_irq_ctrl_c;
			irq_bank_pkg::ADDR_GRP0:   rdata = shared_group_zero;
			irq_bank_pkg::ADDR_GRP1:   rdata = shared_group_one;
			irq_bank_pkg::ADDR_GRP2:   rdata = shared_group_two;
			default:                   rdata = irq_bank_pkg::RESET_VAL;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_edge_select    <= irq_bank_pkg::RESET_VAL;
			primary_irq_ctrl_a <= irq_bank_pkg::RESET_VAL;
			primary_irq_ctrl_b <= irq_bank_pkg::RESET_VAL;
			primary_irq_ctrl_c <= irq_bank_pkg::RESET_VAL;
			grp0_pend_d        <= 1'b0;
			grp1_pend_d        <= 1'b0;
			grp2_pend_d        <= 1'b0;
			o_rdata            <= irq_bank_pkg::RESET_VAL;
		end else begin
			pin_edge_select    <= next_edge;
			primary_irq_ctrl_a <= next_a;
			primary_irq_ctrl_b <= next_b;
			primary_irq_ctrl_c <= next_c;
			grp0_pend_d        <= grp0_pend;
			grp1_pend_d        <= grp1_pend;
			grp2_pend_d        <= grp2_pend;
			o_rdata            <= i_rd ? rdata : irq_bank_pkg::RESET_VAL;
		end
	end

	assign o_irq_req           = any;
	assign o_irq_vec           = vec;
	assign o_global_irq_enable = gie;
endmodule

// >>> hdl/pin_edge_detect.sv
`timescale 1ns/100ps
module pin_edge_detect (
	// clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	// pin and mode
	input  wire logic       i_pin,
	input  wire logic [1:0] i_mode,
	// event
	output logic            o_event
);
	logic prev;
	wire  rise = i_pin & ~prev;
	wire  fall = ~i_pin & prev;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev <= 1'b0;
		end else begin
			prev <= i_pin;
		end
	end

	// trigger decode
	always_comb begin
		case (i_mode)
			irq_bank_pkg::EDGE_OFF:  o_event = 1'b0;
			irq_bank_pkg::EDGE_RISE: o_event = rise;
			irq_bank_pkg::EDGE_FALL: o_event = fall;
			irq_bank_pkg::EDGE_BOTH: o_event = rise | fall;
			default:                 o_event = 1'b0;
		endcase
	end
endmodule

// >>> testbench/cpu_seq_model.sv
`timescale 1ns/100ps
module cpu_seq_model #(
	parameter int LAT = 2
) (
	// clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	// block side
	input  wire logic       i_irq_req,
	input  wire logic [3:0] i_irq_vec,
	input  wire logic       i_enable,
	output logic            o_ack,
	output logic [3:0]      o_vec,
	output logic [7:0]      o_takes
);
	int cnt;
	// takes the request after LAT+1 cycles, one-cycle acknowledge
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ack <= 1'b0;
			o_vec <= 4'h0;
			o_takes <= 8'h00;
			cnt <= 0;
		end else if (o_ack) begin
			o_ack <= 1'b0;
			cnt <= 0;
		end else if (i_enable && i_irq_req) begin
			if (cnt == LAT) begin
				o_ack <= 1'b1;
				o_vec <= i_irq_vec;
				o_takes <= o_takes + 8'h01;
			end else begin
				cnt <= cnt + 1;
			end
		end else begin
			cnt <= 0;
		end
	end
endmodule

// >>> testbench/irq_bank_asserts.sv
`timescale 1ns/100ps
module irq_bank_asserts (
	// clock and reset
	input wire logic       i_ref_clk,
	input wire logic       i_rst_n,
	// register port
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	// sequencer side
	input wire logic       i_ack,
	input wire logic       o_irq_req,
	input wire logic [3:0] o_irq_vec,
	input wire logic       o_global_irq_enable
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);
	// service taken with no software write beside it
	sequence s_take;
		o_irq_req && i_ack && !i_wr;
	endsequence
	sequence s_blocked;
		!o_global_irq_enable && !o_irq_req;
	endsequence
	a_take_blocks: assert property (s_take |=> s_blocked)
		else $error("service did not clear global enable");
	a_req_needs_gie: assert property (o_irq_req |-> o_global_irq_enable)
		else $error("request without global enable");
	a_req_has_vec: assert property (o_irq_req |-> o_irq_vec != 4'h0)
		else $error("request without vector");
	a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (i_rd && i_addr == 3'h7 |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_edge_upper: assert property (i_rd && i_addr == 3'h0 |=> o_rdata[7:4] == 4'h0)
		else $error("edge register upper bits not zero");
	a_ctrl_a_top: assert property (i_rd && i_addr == 3'h1 |=> !o_rdata[7])
		else $error("control a bit 7 not zero");
	a_gie_set: assert property (i_wr && i_addr == 3'h1 && i_wdata[0] |=> o_global_irq_enable)
		else $error("global enable not set by write");
	a_gie_clear: assert property (i_wr && i_addr == 3'h1 && !i_wdata[0] |=> !o_global_irq_enable)
		else $error("global enable not cleared by write");
	a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_irq_req && !o_global_irq_enable)
		else $error("outputs active after reset");
endmodule
bind irq_flag_enable_bank irq_bank_asserts u_irq_bank_asserts (.i_ref_clk, .i_rst_n, .i_addr,
	.i_wdata, .i_wr, .i_rd, .o_rdata, .i_ack, .o_irq_req, .o_irq_vec, .o_global_irq_enable);

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic        i_ref_clk;
	logic        i_rst_n;
	logic [2:0]  i_addr;
	logic [7:0]  i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [7:0]  o_rdata;
	logic        pin0;
	logic        pin1;
	logic [13:0] evts;
	logic        ack;
	logic        req;
	logic [3:0]  vec;
	logic        gie;
	logic        cpu_on;
	logic [3:0]  cpu_vec;
	logic [7:0]  takes;
	int          errors;
	int          total_checks;
	irq_flag_enable_bank #(.LARGE(1'b1)) u_irq_flag_enable_bank (.i_ref_clk, .i_rst_n, .i_addr,
		.i_wdata, .i_wr, .i_rd, .o_rdata, .i_ext_pin0(pin0), .i_ext_pin1(pin1),
		.i_cmp_evt(evts[0]), .i_tick0_evt(evts[1]), .i_tick1_evt(evts[2]), .i_conv_evt(evts[3]),
		.i_ser_evt(evts[4]), .i_aser_evt(evts[5]), .i_t0a_evt(evts[6]), .i_t0p_evt(evts[7]),
		.i_t1a_evt(evts[8]), .i_t1p_evt(evts[9]), .i_t2a_evt(evts[10]), .i_t2p_evt(evts[11]),
		.i_eeprom_evt(evts[12]), .i_low_supply_evt(evts[13]), .i_ack(ack), .o_irq_req(req),
		.o_irq_vec(vec), .o_global_irq_enable(gie));
	cpu_seq_model #(.LAT(2)) u_cpu_seq_model (.i_ref_clk, .i_rst_n, .i_irq_req(req),
		.i_irq_vec(vec), .i_enable(cpu_on), .o_ack(ack), .o_vec(cpu_vec), .o_takes(takes));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask
	task evt(input int i);
		@(posedge i_ref_clk);
		evts <= 14'h0001 << i;
		@(posedge i_ref_clk);
		evts <= 14'h0000;
		@(posedge i_ref_clk);
	endtask
	task pins(input logic v);
		@(posedge i_ref_clk);
		pin0 <= v;
		pin1 <= v;
		repeat (3) @(posedge i_ref_clk);
	endtask
	task t_masks;
		logic [7:0] m[7] = '{irq_bank_pkg::MASK_EDGE, irq_bank_pkg::MASK_A_BIG,
			irq_bank_pkg::MASK_B, irq_bank_pkg::MASK_C_BIG, irq_bank_pkg::MASK_G0,
			irq_bank_pkg::MASK_G1_BIG, irq_bank_pkg::MASK_G2};
		for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
		for (int a = 0; a < 7; a++) wr(a[2:0], 8'hff);
		for (int a = 0; a < 7; a++) rd(a[2:0], m[a]);
		for (int a = 6; a >= 0; a--) wr(a[2:0], 8'h00);
	endtask
	task t_events;
		logic [2:0] ea[14] = '{3'h1, 3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5,
			3'h5, 3'h6, 3'h6};
		logic [7:0] ed[14] = '{8'h20, 8'h80, 8'h10, 8'h40, 8'h40, 8'h80, 8'h20, 8'h10, 8'h20,
			8'h10, 8'h80, 8'h40, 8'h20, 8'h10};
		for (int i = 0; i < 14; i++) begin
			evt(i);
			rd(ea[i], ed[i]);
			wr(ea[i], 8'h00);
		end
	endtask
	task t_edges;
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			wr(3'h0, {4'h0, m, m});
			pins(1'b1);
			rd(3'h1, {3'h0, m[0], 4'h0});
			rd(3'h3, {2'h0, m[0], 5'h0});
			wr(3'h1, 8'h00);
			wr(3'h3, 8'h00);
			pins(1'b0);
			rd(3'h1, {3'h0, m[1], 4'h0});
			rd(3'h3, {2'h0, m[1], 5'h0});
			wr(3'h1, 8'h00);
			wr(3'h3, 8'h00);
		end
	endtask
	task t_service;
		evt(1);
		rd(3'h2, 8'h80);
		wr(3'h1, 8'h02);
		wr(3'h0, 8'h01);
		cpu_on <= 1'b1;
		pins(1'b1);
		chk({7'h0, req}, 8'h00);
		wr(3'h1, 8'h13);
		repeat (6) @(posedge i_ref_clk);
		chk(takes, 8'h01);
		chk({4'h0, cpu_vec}, {4'h0, irq_bank_pkg::VEC_PIN0});
		evt(2);
		rd(3'h1, 8'h02);
		rd(3'h3, 8'h10);
		cpu_on <= 1'b0;
		pins(1'b0);
		for (int a = 0; a < 4; a++) wr(a[2:0], 8'h00);
	endtask
	task t_vectors;
		wr(3'h1, 8'h11);
		@(negedge i_ref_clk);
		chk({7'h0, req}, 8'h00);
		chk({7'h0, gie}, 8'h01);
		wr(3'h1, 8'h25);
		@(negedge i_ref_clk);
		chk({3'h0, req, vec}, {4'h1, irq_bank_pkg::VEC_CMP});
		wr(3'h1, 8'h49);
		@(negedge i_ref_clk);
		chk({3'h0, req, vec}, {4'h1, irq_bank_pkg::VEC_GRP0});
		wr(3'h1, 8'h7f);
		@(negedge i_ref_clk);
		chk({3'h0, req, vec}, {4'h1, irq_bank_pkg::VEC_PIN0});
		wr(3'h1, 8'h00);
	endtask
	task t_groups;
		wr(3'h4, 8'h02);
		evt(7);
		rd(3'h1, 8'h00);
		evt(6);
		rd(3'h4, 8'h32);
		rd(3'h1, 8'h40);
		wr(3'h6, 8'h03);
		evt(12);
		evt(13);
		rd(3'h6, 8'h33);
		rd(3'h2, 8'h20);
		for (int a = 6; a > 0; a--) wr(a[2:0], 8'h00);
	endtask
	task stop_test;
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		#50000;
		errors++;
		stop_test();
	end
	initial begin
		{i_rst_n, i_addr, i_wdata, i_wr, i_rd, pin0, pin1, evts, cpu_on} = '0;
		repeat (3) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		t_masks();
		t_events();
		t_edges();
		t_service();
		t_vectors();
		t_groups();
		stop_test();
	end
endmodule
